// file: src/adc_output_port_config.sv
// Notes on behaviour
// - Select pins 00, 01, 10, 11 give 18-bit parallel, 16-bit parallel, byte parallel and serial ports.
// - Code format high gives straight binary, low gives two's complement by inverting the MSB.
// - The third data pin is always driven and carries result bit 3 except in serial mode.
// - The two lowest shared pins carry bits 1 and 2 in 18-bit parallel mode; in 16-bit and byte modes they select the portion.
// - Internal clock with read after conversion uses the divider inputs to slow the serial clock.
// - In every other serial configuration the divider inputs are ignored.
// - Clock source low makes the device generate and drive the serial clock as master.
// - Clock source high takes the serial clock from the host and shifts data on it.
// - Sync polarity low gives an active-high frame sync, high gives active low.
// - Clock invert flips the serial clock sense for internal and external clocks alike.
// - Outside serial mode the shared pins drive data bits 4 through 8.
// - External clock updates data on the rising edge, or the falling edge when inverted.
// - Internal clock shifts during conversion when read timing is high, after it when low.
module adc_output_port_config #(
	parameter int RESULT_W   = adc_port_pkg::RESULT_W,
	parameter int FIFO_DEPTH = adc_port_pkg::FIFO_DEPTH
) (
	input  wire logic                clk,
	input  wire logic                reset_n,
	input  wire adc_port_pkg::strap_t strapPins,
	input  wire logic [RESULT_W-1:0] convResult,
	input  wire logic                convValid,
	output logic                     convReady,
	input  wire logic                convBusy,
	output adc_port_pkg::par_bus_t   parBus,
	output logic                     serialResultOut,
	output logic                     serialClkOut,
	output logic                     serialClkOe,
	input  wire logic                serialClkIn,
	output logic                     frameSyncOut,
	output adc_port_pkg::iface_mode_t ifaceMode
);
	adc_port_pkg::strap_t strapMeta_r;
	adc_port_pkg::strap_t strap_r;
	logic                 sclkMeta_r;
	logic                 sclkSync_r;
	logic                 sclkPrev_r;

	logic [RESULT_W-1:0]  fifoData;
	logic                 fifoValid;
	logic                 fifoReady;

	adc_port_pkg::ser_state_t state_r;
	adc_port_pkg::ser_state_t state_nxt;
	logic [RESULT_W-1:0]  shift_r;
	logic [RESULT_W-1:0]  shift_nxt;
	logic [RESULT_W-1:0]  held_r;
	logic [RESULT_W-1:0]  held_nxt;
	logic [4:0]           bitCnt_r;
	logic [4:0]           bitCnt_nxt;
	logic [7:0]           divCnt_r;
	logic [7:0]           divCnt_nxt;
	logic                 intClk_r;
	logic                 intClk_nxt;
	logic                 serOut_r;
	logic                 serOut_nxt;
	logic                 sync_r;
	logic                 sync_nxt;
	adc_port_pkg::par_bus_t par_r;
	adc_port_pkg::par_bus_t par_nxt;

	logic                 serialMode;
	logic                 extClk;
	logic                 useDivider;
	logic [7:0]           divLimit;
	logic                 extEdge;
	logic                 tick;
	logic                 mayRead;

	// Format the result per the code format select
	function automatic logic [RESULT_W-1:0] fmt(input logic [RESULT_W-1:0] v, input logic straight);
		fmt = straight ? v : {~v[RESULT_W-1], v[RESULT_W-2:0]};
	endfunction

	// Two-flop synchronisers for straps and the external clock pin
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			strapMeta_r <= '0;
			strap_r     <= '0;
			sclkMeta_r  <= 1'b0;
			sclkSync_r  <= 1'b0;
			sclkPrev_r  <= 1'b0;
		end
		else
		begin
			strapMeta_r <= strapPins;
			strap_r     <= strapMeta_r;
			sclkMeta_r  <= serialClkIn;
			sclkSync_r  <= sclkMeta_r;
			sclkPrev_r  <= sclkSync_r;
		end
	end

	result_fifo #(
		.WIDTH(RESULT_W),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk      (clk),
		.reset_n  (reset_n),
		.inData   (convResult),
		.inValid  (convValid),
		.inReady  (convReady),
		.outData  (fifoData),
		.outValid (fifoValid),
		.outReady (fifoReady)
	);

	// Mode decode and clocking selection
	always_comb
	begin
		ifaceMode  = adc_port_pkg::iface_mode_t'(strap_r.ifaceSel);
		serialMode = (ifaceMode == adc_port_pkg::MODE_SERIAL);
		extClk     = strap_r.clockSourceSel;
		useDivider = !extClk && !strap_r.readTimingSel;
		divLimit   = useDivider ? 8'((8'h01 << strap_r.serialClkDivider) - 8'h01) : 8'h00;
		// External shift edge, rising unless inverted; pin already inverted sense is undone here
		extEdge    = strap_r.serialClkInvert ? (sclkPrev_r && !sclkSync_r)
		                                     : (!sclkPrev_r && sclkSync_r);
		tick       = extClk ? extEdge : (intClk_r && divCnt_r == divLimit);
		mayRead    = extClk || strap_r.readTimingSel || !convBusy;
	end

	// Serial engine and parallel register next state
	always_comb
	begin
		state_nxt  = state_r;
		shift_nxt  = shift_r;
		held_nxt   = held_r;
		bitCnt_nxt = bitCnt_r;
		serOut_nxt = serOut_r;
		sync_nxt   = 1'b0;
		fifoReady  = 1'b0;
		divCnt_nxt = divCnt_r;
		intClk_nxt = intClk_r;
		par_nxt    = par_r;
		// Internal clock divider runs while shifting in master mode
		if (serialMode && !extClk && state_r == adc_port_pkg::SER_SHIFT)
		begin
			if (divCnt_r == divLimit)
			begin
				divCnt_nxt = adc_port_pkg::DIVCNT_RST;
				intClk_nxt = !intClk_r;
			end
			else
				divCnt_nxt = 8'(divCnt_r + 8'h01);
		end
		else
		begin
			divCnt_nxt = adc_port_pkg::DIVCNT_RST;
			intClk_nxt = 1'b0;
		end
		if (!serialMode)
		begin
			// Parallel: latest result is held and presented
			fifoReady  = 1'b1;
			state_nxt  = adc_port_pkg::SER_IDLE;
			if (fifoValid)
				held_nxt = fmt(fifoData, strap_r.codeFormatSel);
			par_nxt.data = '0;
			par_nxt.oe   = '0;
			par_nxt.data[RESULT_W-1:3] = held_r[RESULT_W-1:3];
			par_nxt.oe[RESULT_W-1:3]   = '1;
			case (ifaceMode)
				adc_port_pkg::MODE_PAR18:
				begin
					par_nxt.data[2:0] = held_r[2:0];
					par_nxt.oe[2:1]   = 2'h3;
				end
				default:
				begin
					// Pins 1 and 2 are portion select inputs here
					par_nxt.oe[2:1] = 2'h0;
					case (strap_r.partSel)
						2'h1:    par_nxt.data[RESULT_W-1:RESULT_W-8] = held_r[7:0];
						2'h2:    par_nxt.data[RESULT_W-1:RESULT_W-8] = {6'h00, held_r[RESULT_W-1:RESULT_W-2]};
						default: par_nxt.data[RESULT_W-1:RESULT_W-8] = held_r[RESULT_W-1:RESULT_W-8];
					endcase
				end
			endcase
			par_nxt.oe[0] = 1'b1;
		end
		else
		begin
			par_nxt.data = '0;
			par_nxt.oe   = '0;
			par_nxt.oe[3] = 1'b1;
			case (state_r)
				adc_port_pkg::SER_IDLE:
				begin
					if (fifoValid && mayRead)
					begin
						fifoReady  = 1'b1;
						shift_nxt  = fmt(fifoData, strap_r.codeFormatSel);
						serOut_nxt = shift_nxt[RESULT_W-1];
						bitCnt_nxt = 5'(RESULT_W - 1);
						sync_nxt   = 1'b1;
						state_nxt  = adc_port_pkg::SER_SHIFT;
					end
				end
				adc_port_pkg::SER_SHIFT:
				begin
					sync_nxt = 1'b1;
					if (tick)
					begin
						if (bitCnt_r == adc_port_pkg::BITCNT_RST)
							state_nxt = adc_port_pkg::SER_DONE;
						else
						begin
							shift_nxt  = {shift_r[RESULT_W-2:0], 1'b0};
							serOut_nxt = shift_r[RESULT_W-2];
							bitCnt_nxt = 5'(bitCnt_r - 5'h01);
						end
					end
				end
				adc_port_pkg::SER_DONE:
					state_nxt = adc_port_pkg::SER_IDLE;
				default:
					state_nxt = adc_port_pkg::SER_IDLE;
			endcase
		end
	end

	// Engine registers
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			state_r  <= adc_port_pkg::SER_IDLE;
			shift_r  <= adc_port_pkg::RESULT_RST;
			held_r   <= adc_port_pkg::RESULT_RST;
			bitCnt_r <= adc_port_pkg::BITCNT_RST;
			divCnt_r <= adc_port_pkg::DIVCNT_RST;
			intClk_r <= 1'b0;
			serOut_r <= 1'b0;
			sync_r   <= 1'b0;
			par_r    <= '0;
		end
		else
		begin
			state_r  <= state_nxt;
			shift_r  <= shift_nxt;
			held_r   <= held_nxt;
			bitCnt_r <= bitCnt_nxt;
			divCnt_r <= divCnt_nxt;
			intClk_r <= intClk_nxt;
			serOut_r <= serOut_nxt;
			sync_r   <= sync_nxt;
			par_r    <= par_nxt;
		end
	end

	// Serial pins: clock inversion and sync polarity applied at the output
	always_comb
	begin
		parBus          = par_r;
		serialResultOut = serialMode ? serOut_r : 1'b0;
		serialClkOe     = serialMode && !extClk;
		serialClkOut    = intClk_r ^ strap_r.serialClkInvert;
		frameSyncOut    = serialMode ? (sync_r ^ strap_r.syncPolaritySel) : 1'b0;
	end
endmodule

// file: src/adc_port_pkg.sv
package adc_port_pkg;

	// Interface mode codes on the two select pins
	typedef enum logic [1:0]
	{
		MODE_PAR18  = 2'h0,
		MODE_PAR16  = 2'h1,
		MODE_BYTE   = 2'h2,
		MODE_SERIAL = 2'h3
	} iface_mode_t;

	// Serial engine states, one-hot
	typedef enum logic [2:0]
	{
		SER_IDLE  = 3'h1,
		SER_SHIFT = 3'h2,
		SER_DONE  = 3'h4
	} ser_state_t;

	localparam int RESULT_W      = 18;
	localparam int FIFO_DEPTH    = 32;
	localparam int SYNC_STAGES   = 2;
	localparam int DIV_BASE      = 1;
	localparam logic [RESULT_W-1:0] RESULT_RST = 18'h00000;
	localparam logic [4:0] BITCNT_RST = 5'h00;
	localparam logic [7:0] DIVCNT_RST = 8'h00;

	// Strap bundle sampled from the configuration pins
	typedef struct packed
	{
		logic [1:0] ifaceSel;
		logic       codeFormatSel;
		logic       clockSourceSel;
		logic       syncPolaritySel;
		logic       serialClkInvert;
		logic       readTimingSel;
		logic [1:0] serialClkDivider;
		logic [1:0] partSel;
	} strap_t;

	// Parallel pin group: level and output enable per data pin
	typedef struct packed
	{
		logic [RESULT_W-1:0] data;
		logic [RESULT_W-1:0] oe;
	} par_bus_t;

endpackage

// file: src/result_fifo.sv
module result_fifo #(
	parameter int WIDTH = 18,
	parameter int DEPTH = 32
) (
	input  wire logic             clk,
	input  wire logic             reset_n,
	input  wire logic [WIDTH-1:0] inData,
	input  wire logic             inValid,
	output logic                  inReady,
	output logic      [WIDTH-1:0] outData,
	output logic                  outValid,
	input  wire logic             outReady
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wrPtr_r;
	logic [AW-1:0]    wrPtr_nxt;
	logic [AW-1:0]    rdPtr_r;
	logic [AW-1:0]    rdPtr_nxt;
	logic [AW:0]      count_r;
	logic [AW:0]      count_nxt;
	logic             doWr;
	logic             doRd;

	// Honest full and empty from the occupancy count
	always_comb
	begin
		inReady   = (count_r != (AW+1)'(DEPTH));
		outValid  = (count_r != '0);
		doWr      = inValid && inReady;
		doRd      = outValid && outReady;
		wrPtr_nxt = doWr ? AW'(wrPtr_r + 1'b1) : wrPtr_r;
		rdPtr_nxt = doRd ? AW'(rdPtr_r + 1'b1) : rdPtr_r;
		count_nxt = count_r;
		if (doWr && !doRd)
			count_nxt = (AW+1)'(count_r + 1'b1);
		else if (doRd && !doWr)
			count_nxt = (AW+1)'(count_r - 1'b1);
	end

	// Pointers and count
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			wrPtr_r <= '0;
			rdPtr_r <= '0;
			count_r <= '0;
		end
		else
		begin
			wrPtr_r <= wrPtr_nxt;
			rdPtr_r <= rdPtr_nxt;
			count_r <= count_nxt;
		end
	end

	// Storage has no reset
	always_ff @(posedge clk)
	begin
		if (doWr)
			mem[wrPtr_r] <= inData;
	end

	assign outData = mem[rdPtr_r];
endmodule

// file: tb/adc_port_checker.sv
module adc_port_checker #(
	parameter int RESULT_W   = 18,
	parameter int FIFO_DEPTH = 32
) (
	input wire logic                      clk,
	input wire logic                      reset_n,
	input wire adc_port_pkg::strap_t      strapPins,
	input wire logic [RESULT_W-1:0]       convResult,
	input wire logic                      convValid,
	input wire logic                      convReady,
	input wire logic                      convBusy,
	input wire adc_port_pkg::par_bus_t    parBus,
	input wire logic                      serialResultOut,
	input wire logic                      serialClkOut,
	input wire logic                      serialClkOe,
	input wire logic                      serialClkIn,
	input wire logic                      frameSyncOut,
	input wire adc_port_pkg::iface_mode_t ifaceMode
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!reset_n);

	// Straps settled long enough to pass the synchronisers
	sequence sStill;
		$stable(strapPins) [*4];
	endsequence
	sequence sSer2;
		(ifaceMode == adc_port_pkg::MODE_SERIAL) [*2];
	endsequence
	sequence sPar2;
		(ifaceMode != adc_port_pkg::MODE_SERIAL) [*2];
	endsequence
	// Internal clock selected and no frame running
	sequence sIdleInt;
		(ifaceMode == adc_port_pkg::MODE_SERIAL && !strapPins.clockSourceSel
			&& frameSyncOut == strapPins.syncPolaritySel) [*4];
	endsequence

	a_mode_from_straps: assert property (sStill |-> ifaceMode == strapPins.ifaceSel)
		else $error("mode decode wrong");
	a_bit3_driven: assert property ($past(reset_n) |-> parBus.oe[3])
		else $error("third data pin not driven");
	a_bus18_driven: assert property ((ifaceMode == adc_port_pkg::MODE_PAR18) [*2] |-> &parBus.oe)
		else $error("full bus not driven");
	a_low_pins_in: assert property ((ifaceMode == adc_port_pkg::MODE_PAR16 || ifaceMode == adc_port_pkg::MODE_BYTE) [*2]
		|-> parBus.oe[2:1] == 2'h0)
		else $error("portion select pins driven");
	a_shared_out: assert property (sPar2 |-> &parBus.oe[8:4])
		else $error("shared pins not driven");
	a_shared_in: assert property (sSer2 |-> parBus.oe[8:4] == 5'h00)
		else $error("shared pins driven in serial");
	a_clk_master: assert property (sStill |-> serialClkOe
		== (ifaceMode == adc_port_pkg::MODE_SERIAL && !strapPins.clockSourceSel))
		else $error("serial clock direction wrong");
	a_quiet_parallel: assert property (sPar2 |-> !frameSyncOut && !serialResultOut)
		else $error("serial outputs active in parallel");
	a_idle_clk_sense: assert property (sStill ##0 sIdleInt |-> serialClkOut == strapPins.serialClkInvert)
		else $error("idle serial clock sense wrong");
endmodule

bind adc_output_port_config adc_port_checker #(.RESULT_W(RESULT_W), .FIFO_DEPTH(FIFO_DEPTH)) u_chk (.clk, .reset_n,
	.strapPins, .convResult, .convValid, .convReady, .convBusy, .parBus, .serialResultOut, .serialClkOut,
	.serialClkOe, .serialClkIn, .frameSyncOut, .ifaceMode);

// file: tb/host_reader.sv
module host_reader (
	input  wire logic   clk,
	input  wire logic   extMode,
	input  wire logic   clkInv,
	input  wire logic   syncLow,
	input  wire logic   serialClkOut,
	input  wire logic   serialResultOut,
	input  wire logic   frameSyncOut,
	output logic        serialClkIn,
	output logic [17:0] rxWord
);
	timeunit 1ns;
	timeprecision 1ps;
	logic inFrame;
	logic prev;
	int   n;
	assign inFrame = frameSyncOut ^ syncLow;
	// Reads one word per frame; the external clock stands at its idle level between frames
	initial
	begin
		serialClkIn = 1'h0;
		rxWord = 18'h00000;
		forever
		begin
			@(negedge clk);
			serialClkIn = clkInv;
			n = 0;
			prev = 1'h0;
			while (inFrame && n < 18)
			begin
				if (extMode)
				begin
					repeat (4) @(negedge clk);
					// A strap change can fake a short frame; only clock while the frame still stands
					if (inFrame)
					begin
						rxWord = {rxWord[16:0], serialResultOut};
						n++;
						serialClkIn = ~serialClkIn;
						repeat (4) @(negedge clk);
						serialClkIn = ~serialClkIn;
					end
				end
				else
				begin
					@(negedge clk);
					if ((serialClkOut ^ clkInv) && !prev)
					begin
						rxWord = {rxWord[16:0], serialResultOut};
						n++;
					end
					prev = serialClkOut ^ clkInv;
				end
			end
			wait (!inFrame);
		end
	end
endmodule

// file: tb/test_adc_output_port_config.sv
module test_adc_output_port_config;
	timeunit 1ns;
	timeprecision 1ps;
	logic                      clk = 1'h0;
	logic                      reset_n = 1'h0;
	adc_port_pkg::strap_t      strapPins = '0;
	logic [17:0]               convResult = 18'h00000;
	logic                      convValid = 1'h0;
	logic                      convBusy = 1'h0;
	logic                      convReady, serialResultOut, serialClkOut, serialClkOe, serialClkIn, frameSyncOut;
	adc_port_pkg::par_bus_t    parBus;
	adc_port_pkg::iface_mode_t ifaceMode;
	logic [17:0]               rxWord;
	int                        error_cnt = 0;
	int                        n_tests = 0;
	int                        l0, l1, l2, l3;

	always #12.5 clk = ~clk;

	adc_output_port_config u_dut (.clk, .reset_n, .strapPins, .convResult, .convValid, .convReady, .convBusy,
		.parBus, .serialResultOut, .serialClkOut, .serialClkOe, .serialClkIn, .frameSyncOut, .ifaceMode);
	host_reader u_host (.clk, .extMode(strapPins.clockSourceSel), .clkInv(strapPins.serialClkInvert),
		.syncLow(strapPins.syncPolaritySel), .serialClkOut, .serialResultOut, .frameSyncOut, .serialClkIn, .rxWord);

	task automatic chk(input string nm, input logic [17:0] seen, input logic [17:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("FAIL %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic setStraps(input adc_port_pkg::strap_t s);
		@(negedge clk);
		strapPins = s;
		repeat (5) @(negedge clk);
	endtask

	task automatic push(input logic [17:0] v);
		@(negedge clk);
		convResult = v;
		convValid = 1'h1;
		while (convReady !== 1'h1) @(negedge clk);
		@(negedge clk);
		convValid = 1'h0;
	endtask

	// Parallel modes: pin directions and result placement
	task automatic tPar(input logic [1:0] m, input logic f, input logic [1:0] p, input logic [17:0] v);
		adc_port_pkg::strap_t s;
		logic [17:0]          e;
		s = '0;
		s.ifaceSel = m;
		s.codeFormatSel = f;
		s.partSel = p;
		e = f ? v : v ^ 18'h20000;
		setStraps(s);
		push(v);
		repeat (6) @(negedge clk);
		chk("oe3", parBus.oe[3], 1'h1);
		chk("oe8to4", parBus.oe[8:4], 5'h1F);
		if (m == 2'h0) chk("par18", parBus.data, e);
		else if (m == 2'h1)
		begin
			chk("oe2to1", parBus.oe[2:1], 2'h0);
			chk("par16", parBus.data[17:3], e[17:3]);
		end
		else if (p == 2'h2) chk("byteTop", parBus.data[17:10], {6'h00, e[17:16]});
		else chk("byte", parBus.data[17:10], p[0] ? e[7:0] : e[17:10]);
	endtask

	// Serial frame: read back through the host model and measure the frame length
	task automatic tSer(input logic e, i, p, input logic [1:0] d, input logic r, b, input logic [17:0] v,
		output int len);
		adc_port_pkg::strap_t s;
		int                   w;
		s = '0;
		s.ifaceSel = 2'h3;
		s.codeFormatSel = 1'h1;
		s.clockSourceSel = e;
		s.serialClkInvert = i;
		s.syncPolaritySel = p;
		s.serialClkDivider = d;
		s.readTimingSel = r;
		setStraps(s);
		chk("syncIdle", frameSyncOut, p);
		convBusy = b;
		push(v);
		if (b)
		begin
			repeat (20) @(negedge clk);
			chk("heldBusy", frameSyncOut, p);
			convBusy = 1'h0;
		end
		w = 0;
		len = 0;
		while (frameSyncOut === p && w < 100)
		begin
			@(negedge clk);
			w++;
		end
		while (frameSyncOut !== p && len < 3000)
		begin
			@(negedge clk);
			len++;
		end
		chk("word", rxWord, v);
	endtask

	// Fill the buffer while the serial engine waits, then drain it
	task automatic tFill;
		adc_port_pkg::strap_t s;
		int                   n;
		s = '0;
		s.ifaceSel = 2'h3;
		s.codeFormatSel = 1'h1;
		setStraps(s);
		convBusy = 1'h1;
		n = 0;
		repeat (40)
		begin
			@(negedge clk);
			n += (convReady === 1'h1);
			convValid = 1'h1;
		end
		@(negedge clk);
		convValid = 1'h0;
		chk("fill", n >= 32 && n <= 33, 1'h1);
		convBusy = 1'h0;
		repeat (2500) @(negedge clk);
		chk("drain", convReady, 1'h1);
		chk("drained", frameSyncOut, 1'h0);
	endtask

	task automatic results;
		$display("checks %0d errors %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// Watchdog sized well above the full sequence
	initial
	begin
		#(25 * 30000);
		error_cnt++;
		results();
	end

	initial
	begin
		repeat (20) @(negedge clk);
		reset_n = 1'h1;
		repeat (3) @(negedge clk);
		tPar(2'h0, 1'h1, 2'h0, 18'h2A5C3);
		tPar(2'h0, 1'h0, 2'h0, 18'h3F00C);
		tPar(2'h1, 1'h1, 2'h0, 18'h12345);
		tPar(2'h2, 1'h0, 2'h0, 18'h2A5C3);
		tPar(2'h2, 1'h1, 2'h1, 18'h2A5C3);
		tPar(2'h2, 1'h1, 2'h2, 18'h2A5C3);
		tSer(1'h0, 1'h0, 1'h0, 2'h0, 1'h0, 1'h0, 18'h2D1B4, l0);
		tSer(1'h0, 1'h0, 1'h0, 2'h1, 1'h0, 1'h0, 18'h2D1B4, l1);
		tSer(1'h0, 1'h0, 1'h0, 2'h2, 1'h0, 1'h0, 18'h2D1B4, l2);
		chk("divider", (l2 - l1) === 2 * (l1 - l0), 1'h1);
		tSer(1'h0, 1'h0, 1'h0, 2'h2, 1'h1, 1'h0, 18'h2D1B4, l3);
		chk("noDivider", l3 === l0, 1'h1);
		tSer(1'h0, 1'h1, 1'h1, 2'h0, 1'h0, 1'h1, 18'h1C3A5, l3);
		tSer(1'h1, 1'h0, 1'h0, 2'h3, 1'h0, 1'h0, 18'h1C3A5, l3);
		tSer(1'h1, 1'h1, 1'h1, 2'h0, 1'h0, 1'h0, 18'h2D1B4, l3);
		tFill();
		results();
	end
endmodule
